// >>> verilog/acc_capture.sv
// Capture controller: direct record, histogram, serial return
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module acc_capture
  import acc_pkg::*;
#(
  parameter int unsigned ALIVE_CYCLES = acc_pkg::ALIVE_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [4:0]                   sw,
  input  wire logic                         sample_valid_strobe,
  input  wire logic                         alt_strobe,
  input  wire logic [acc_pkg::SMP_W-1:0]    conv_data,
  input  wire logic                         uart_rxd,
  output logic                              uart_txd,
  output logic [acc_pkg::ADDR_W-1:0]        sram_addr,
  output logic [acc_pkg::WORD_W-1:0]        sram_dout,
  output logic                              sram_oe,
  input  wire logic [acc_pkg::WORD_W-1:0]   sram_din,
  output logic                              sram_we_n,
  output logic                              clk_out,
  output logic                              led1,
  output logic                              led2,
  output logic                              led6,
  input  wire logic [3:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [3:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import acc_pkg::*;

  typedef struct packed {
    acc_state_e          st;
    logic [2:0]          cs;
    logic                cs_q;
    logic [2:0]          as;
    logic                as_q;
    logic [SMP_W-1:0]    d1;
    logic [SMP_W-1:0]    d2;
    logic [SMP_W-1:0]    d3;
    logic [SMP_W-1:0]    dq;
    logic [4:0]          w1;
    logic [4:0]          w2;
    logic [4:0]          w3;
    logic [4:0]          wq;
    logic                div2;
    logic                led1;
    logic                led2;
    logic                led6;
    logic [ADDR_W-1:0]   addr;
    logic [WORD_W-1:0]   wdata;
    logic                we;
    logic                oe;
    logic [ADDR_W-1:0]   cnt;
    logic [3:0]          skip;
    logic [WORD_W-1:0]   word;
    logic [1:0]          bsel;
    logic                hist;
    logic                paused;
    logic [7:0]          txd;
    logic                txv;
    logic [15:0]         acnt;
    logic                alive;
    logic                en;
    logic                awready;
    logic                arready;
    logic                bvalid;
    logic                rvalid;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } acc_cap_s;

  acc_cap_s r, n;
  logic [SMP_W-1:0] fifo_mem [1 << ADDR_W];
  logic [SMP_W-1:0] fifo_q;
  logic             fifo_we;
  logic [7:0]       rx_data;
  logic             rx_valid;
  logic             tx_ready;
  logic             sel_rise;
  logic [SMP_W-1:0] aligned;
  logic [SMP_W-1:0] offset_bin;
  logic [ADDR_W-1:0] bin;
  logic [23:0]      stop_cnt;
  logic [1:0]       width_sel;
  logic [1:0]       stop_sel;

  // ==========================================================
  // Serial port
  acc_uart #(
    .DIV (BAUD_DIV)
  ) u_uart (
    .clk      (clk),
    .reset    (reset),
    .rxd      (uart_rxd),
    .tx_data  (r.txd),
    .tx_valid (r.txv),
    .tx_ready (tx_ready),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .txd      (uart_txd)
  );

  // ==========================================================
  // Sample path
  always_comb begin
    // Lower-numbered switch is the upper index bit
    width_sel  = {r.wq[1], r.wq[2]};
    stop_sel   = {r.wq[3], r.wq[4]};
    aligned    = r.wq[0] ? (r.dq & WMASK[width_sel]) : r.dq;
    offset_bin = r.hist ? (aligned ^ WMSB[width_sel]) : aligned;
    bin        = ADDR_W'(offset_bin >> BSHIFT[width_sel]);
    stop_cnt   = STOP[stop_sel];
  end

  // ==========================================================
  // Next state
  always_comb begin
    n          = r;
    n.we       = 1'b0;
    n.txv      = 1'b0;
    fifo_we    = 1'b0;
    n.cs       = {r.cs[1:0], sample_valid_strobe};
    n.as       = {r.as[1:0], alt_strobe};
    n.d1       = conv_data;
    n.d2       = r.d1;
    n.d3       = r.d2;
    n.w1       = sw;
    n.w2       = r.w1;
    n.w3       = r.w2;
    if (r.cs[1] == r.cs[2]) n.cs_q = r.cs[2];
    if (r.as[1] == r.as[2]) n.as_q = r.as[2];
    if (r.d2 == r.d3) n.dq = r.d3;
    if (r.w2 == r.w3) n.wq = r.w3;
    sel_rise = r.wq[0] ? (n.cs_q && !r.cs_q) : (n.as_q && !r.as_q);
    n.led6   = r.wq[0] ? r.cs_q : r.as_q;
    if (sel_rise) n.div2 = !r.div2;
    if (sel_rise) begin
      n.acnt  = 16'h0000;
      n.alive = 1'b1;
    end else if (r.acnt == 16'(ALIVE_CYCLES - 1)) begin
      n.alive = 1'b0;
    end else begin
      n.acnt = r.acnt + 16'h0001;
    end
    // In-band flow control; modem lines have no port at all
    if (rx_valid && rx_data == CH_PAUSE) n.paused = 1'b1;
    if (rx_valid && rx_data == CH_RESUME) n.paused = 1'b0;

    unique case (r.st)
      ST_IDLE: begin
        if (rx_valid && rx_data == CMD_PING && r.alive && tx_ready) begin
          n.txd = CMD_PING;
          n.txv = 1'b1;
        end
        if (rx_valid && r.en && rx_data == CMD_DIRECT) begin
          n.st   = ST_CAPT;
          n.hist = 1'b0;
          n.cnt  = '0;
        end
        if (rx_valid && r.en && rx_data == CMD_HIST) begin
          n.st   = ST_CLEAR;
          n.hist = 1'b1;
          n.addr = '0;
          n.skip = '0;
        end
      end
      ST_CAPT: begin
        if (sel_rise) begin
          fifo_we = 1'b1;
          n.cnt   = r.cnt + 1'b1;
          if (r.cnt == LAST_ADDR) begin
            n.st   = ST_FETCH;
            n.led2 = 1'b1;
          end
        end
      end
      ST_CLEAR: begin
        n.oe    = 1'b1;
        n.wdata = '0;
        n.led1  = r.addr[LED_BIT];
        if (!r.we) begin
          n.we = 1'b1;
        end else begin
          n.addr = r.addr + 1'b1;
          if (r.addr == LAST_ADDR) begin
            n.st = ST_HWAIT;
            n.oe = 1'b0;
          end
        end
      end
      ST_HWAIT: begin
        n.oe = 1'b0;
        if (sel_rise) begin
          if (r.skip == SKIP_LAST) begin
            n.skip = '0;
            n.addr = bin;
            n.st   = ST_HREAD;
          end else begin
            n.skip = r.skip + 4'h1;
          end
        end
      end
      ST_HREAD: begin
        n.wdata = sram_din + 24'h000001;
        n.oe    = 1'b1;
        n.we    = 1'b1;
        n.led1  = r.addr[LED_BIT];
        n.st    = ST_HWRITE;
      end
      ST_HWRITE: begin
        n.oe = 1'b0;
        if (r.wdata == stop_cnt) begin
          n.st   = ST_FETCH;
          n.cnt  = '0;
          n.led2 = 1'b1;
        end else begin
          n.st = ST_HWAIT;
        end
      end
      ST_FETCH: begin
        n.addr = r.cnt;
        n.st   = ST_LOAD;
        if (r.hist) n.led1 = r.cnt[LED_BIT];
      end
      ST_LOAD: begin
        n.word = r.hist ? sram_din : WORD_W'(fifo_q);
        n.bsel = '0;
        n.st   = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready && !r.txv && !r.paused) begin
          n.txv  = 1'b1;
          n.bsel = r.bsel + 2'h1;
          unique case (r.bsel)
            2'h0:    n.txd = r.word[23:16];
            2'h1:    n.txd = r.word[15:8];
            default: n.txd = r.word[7:0];
          endcase
          if (r.bsel == LAST_BYTE) begin
            n.cnt = r.cnt + 1'b1;
            n.st  = ST_FETCH;
            if (r.cnt == LAST_ADDR) begin
              n.st   = ST_IDLE;
              n.led2 = 1'b0;
              n.led1 = 1'b0;
            end
          end
        end
      end
    endcase

    // ==========================================================
    // Register bus
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    n.awready = 1'b0;
    n.arready = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awready) begin
      n.awready = 1'b1;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_DECERR;
      if (s_axi_awaddr == A_CTRL) begin
        n.bresp = RESP_OKAY;
        if (s_axi_wstrb[0]) n.en = s_axi_wdata[0];
      end
    end
    if (s_axi_arvalid && !r.rvalid && !r.arready) begin
      n.arready = 1'b1;
      n.rvalid  = 1'b1;
      n.rresp   = RESP_OKAY;
      n.rdata   = '0;
      unique case (s_axi_araddr)
        A_CTRL:  n.rdata = {31'h00000000, r.en};
        A_STAT:  n.rdata = {19'h00000, r.alive, r.paused, r.led2, r.hist, r.st};
        A_COUNT: n.rdata = {17'h00000, r.cnt};
        default: n.rresp = RESP_DECERR;
      endcase
    end
  end

  // ==========================================================
  // Registers and record memory
  always_ff @(posedge clk) begin
    if (reset) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.led1   <= 1'b1;
      r.paused <= 1'b0;
      r.en     <= CTRL_RST;
      r.cs     <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (fifo_we) fifo_mem[r.cnt] <= aligned;
    fifo_q <= fifo_mem[n.addr];
  end

  assign sram_addr     = r.addr;
  assign sram_dout     = r.wdata;
  assign sram_oe       = r.oe;
  assign sram_we_n     = !r.we;
  assign clk_out       = r.div2;
  assign led1          = r.led1;
  assign led2          = r.led2;
  assign led6          = r.led6;
  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.awready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rresp   = r.rresp;
  assign s_axi_rdata   = r.rdata;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_pause_holds: assert property (
    r.paused && r.st == ST_SEND && !(rx_valid && rx_data == CH_RESUME) |=> !r.txv [*2])
    else $error("byte sent while paused");
  a_resume_clears: assert property (
    rx_valid && rx_data == CH_RESUME && rx_data != CH_PAUSE |=> !r.paused)
    else $error("resume not taken");
  a_init_resumed: assert property (
    $fell(reset) |-> !r.paused)
    else $error("flow paused after reset");
  a_clock_half: assert property (
    sel_rise |=> clk_out != $past(clk_out))
    else $error("clock output missed a toggle");
  a_stop_reached: assert property (
    r.st == ST_HWRITE && r.wdata == stop_cnt |=> r.st == ST_FETCH ##1 r.st == ST_LOAD)
    else $error("histogram did not stop");
  a_skip_eleven: assert property (
    r.st == ST_HWAIT && sel_rise && r.skip != SKIP_LAST |=> r.st == ST_HWAIT)
    else $error("sample counted too early");
  a_upper_zero: assert property (
    fifo_we && r.wq[0] |-> (aligned & ~WMASK[width_sel]) == '0)
    else $error("upper bits not cleared");
  a_msb_first: assert property (
    r.st == ST_SEND && r.txv && r.bsel == 2'h1 |-> r.txd == r.word[23:16])
    else $error("first byte not most significant");
  a_waiting_lit: assert property (
    r.st inside {ST_FETCH, ST_LOAD, ST_SEND} |-> led2)
    else $error("indicator 2 dark while sending");
  a_bus_write: assert property (
    s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awready |=> s_axi_bvalid && s_axi_awready)
    else $error("write not answered");
endmodule : acc_capture
`default_nettype wire

// >>> verilog/acc_pkg.sv
// Constants shared by the capture controller and its serial port
package acc_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CLK_NS       = 20;
  localparam int unsigned BAUD         = 115_200;
  localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD;
  localparam int unsigned ALIVE_NS     = 1_000_000;
  localparam int unsigned ALIVE_CYC    = ALIVE_NS / CLK_NS;
  localparam int unsigned SMP_W        = 18;
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned WORD_W       = 24;
  localparam int unsigned LED_BIT      = 10;
  localparam logic [14:0] LAST_ADDR    = 15'h7FFF;
  localparam logic [3:0]  SKIP_LAST    = 4'hB;
  localparam logic [1:0]  LAST_BYTE    = 2'h2;
  localparam logic [7:0]  CH_PAUSE     = 8'h13;
  localparam logic [7:0]  CH_RESUME    = 8'h11;
  localparam logic [7:0]  CMD_PING     = 8'h3F;
  localparam logic [7:0]  CMD_DIRECT   = 8'h44;
  localparam logic [7:0]  CMD_HIST     = 8'h48;
  // Indexed by {switch 2, switch 3}: 18, 16, 14, 12 bits
  localparam logic [17:0] WMASK [4]    = '{18'h3FFFF, 18'h0FFFF, 18'h03FFF, 18'h00FFF};
  localparam logic [17:0] WMSB  [4]    = '{18'h20000, 18'h08000, 18'h02000, 18'h00800};
  localparam logic [1:0]  BSHIFT [4]   = '{2'h3, 2'h1, 2'h0, 2'h0};
  // Indexed by {switch 4, switch 5}
  localparam logic [23:0] STOP  [4]    = '{24'h004000, 24'h002000, 24'h001000, 24'h000800};
  localparam logic [3:0]  A_CTRL       = 4'h0;
  localparam logic [3:0]  A_STAT       = 4'h4;
  localparam logic [3:0]  A_COUNT      = 4'h8;
  localparam logic        CTRL_RST     = 1'b1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001, ST_CLEAR = 9'h002, ST_HWAIT = 9'h004,
    ST_HREAD = 9'h008, ST_HWRITE = 9'h010, ST_CAPT = 9'h020,
    ST_FETCH = 9'h040, ST_LOAD  = 9'h080, ST_SEND  = 9'h100
  } acc_state_e;
endpackage : acc_pkg

// >>> verilog/acc_uart.sv
// Serial port: 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
`default_nettype none
module acc_uart
  import acc_pkg::*;
#(
  parameter int unsigned DIV = acc_pkg::BAUD_DIV
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rxd,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            txd
);
  typedef struct packed {
    logic [2:0]  rs;
    logic        rlev;
    logic        rbusy;
    logic [15:0] rcnt;
    logic [3:0]  rbit;
    logic [7:0]  rsh;
    logic [7:0]  rdat;
    logic        rv;
    logic        tbusy;
    logic [15:0] tcnt;
    logic [3:0]  tbit;
    logic [9:0]  tsh;
    logic        txd;
  } acc_uart_s;
  acc_uart_s r, n;

  always_comb begin
    n = r;
    n.rv = 1'b0;
    n.rs = {r.rs[1:0], rxd};
    if (r.rs[1] == r.rs[2]) n.rlev = r.rs[2];
    // Receiver: sample mid-bit, drop false starts and bad stops
    if (!r.rbusy) begin
      if (!r.rlev) begin
        n.rbusy = 1'b1;
        n.rcnt  = 16'(DIV / 2);
        n.rbit  = 4'h0;
      end
    end else if (r.rcnt == 16'h0000) begin
      n.rcnt = 16'(DIV - 1);
      n.rbit = r.rbit + 4'h1;
      if (r.rbit == 4'h0) begin
        if (r.rlev) n.rbusy = 1'b0;
      end else if (r.rbit < 4'h9) begin
        n.rsh = {r.rlev, r.rsh[7:1]};
      end else begin
        n.rbusy = 1'b0;
        n.rv    = r.rlev;
        n.rdat  = r.rsh;
      end
    end else begin
      n.rcnt = r.rcnt - 16'h0001;
    end
    // Transmitter: start, eight data bits LSB first, stop
    if (!r.tbusy) begin
      if (tx_valid) begin
        n.tbusy = 1'b1;
        n.tsh   = {1'b1, tx_data, 1'b0};
        n.tcnt  = 16'(DIV - 1);
        n.tbit  = 4'h0;
      end
    end else if (r.tcnt == 16'h0000) begin
      n.tcnt = 16'(DIV - 1);
      n.tsh  = {1'b1, r.tsh[9:1]};
      n.tbit = r.tbit + 4'h1;
      if (r.tbit == 4'h9) n.tbusy = 1'b0;
    end else begin
      n.tcnt = r.tcnt - 16'h0001;
    end
    n.txd = n.tbusy ? n.tsh[0] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r      <= '0;
      r.rs   <= 3'h7;
      r.rlev <= 1'b1;
      r.txd  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign tx_ready = !r.tbusy;
  assign rx_data  = r.rdat;
  assign rx_valid = r.rv;
  assign txd      = r.txd;

  a_frame_length: assert property (@(posedge clk) disable iff (reset)
    $rose(r.tbusy) |-> r.tbusy [*8] ##1 r.tbusy)
    else $error("transmit frame ended early");
endmodule : acc_uart
`default_nettype wire

// >>> verification/acc_host_model.sv
// Host serial port, converter strobe source and SRAM model
`timescale 1ns/1ns
`default_nettype none
module acc_host_model
  import acc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       uart_txd,
  output logic                            uart_rxd,
  output logic                            strobe,
  output logic [acc_pkg::SMP_W-1:0]       conv_data,
  input  wire logic [acc_pkg::ADDR_W-1:0] sram_addr,
  input  wire logic [acc_pkg::WORD_W-1:0] sram_dout,
  input  wire logic                       sram_oe,
  input  wire logic                       sram_we_n,
  output logic [acc_pkg::WORD_W-1:0]      sram_din,
  output logic [7:0]                      rx_byte,
  output logic                            rx_pulse
);
  import acc_pkg::*;
  logic [23:0] mem [32768];
  logic        run;
  int unsigned phase;

  initial begin
    uart_rxd = 1'b1;
    strobe = 1'b0;
    conv_data = '0;
    run = 1'b0;
    rx_byte = '0;
    rx_pulse = 1'b0;
    phase = 0;
    // Dirty contents so clearing is visible
    for (int i = 0; i < 32768; i++) mem[i] = 24'hA5A5A5 ^ 24'(i);
  end

  // ==========================================
  // Converter strobe, free running or in bursts
  always @(posedge clk) begin
    if (run) begin
      phase <= phase + 1;
      if (phase % 4 == 3) strobe <= !strobe;
    end
  end

  task automatic burst(input int n, input logic [17:0] d);
    @(posedge clk);
    strobe <= 1'b0;
    conv_data <= d;
    repeat (4) @(posedge clk);
    repeat (n) begin
      strobe <= 1'b1;
      repeat (4) @(posedge clk);
      strobe <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : burst

  // ==========================================
  // Asynchronous SRAM; bus shows junk while device drives it
  always @(posedge clk) begin
    if (!sram_we_n) mem[sram_addr] <= sram_dout;
  end
  assign sram_din = sram_oe ? ~sram_dout : mem[sram_addr];

  // ==========================================
  // Serial port, 8N1, LSB first
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    uart_rxd <= 1'b0;
    repeat (BAUD_DIV) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      uart_rxd <= b[i];
      repeat (BAUD_DIV) @(posedge clk);
    end
    uart_rxd <= 1'b1;
    repeat (BAUD_DIV) @(posedge clk);
  endtask : send

  always begin
    @(negedge uart_txd);
    repeat (BAUD_DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(posedge clk);
      rx_byte[i] = uart_txd;
    end
    repeat (BAUD_DIV) @(posedge clk);
    // Bad stop bit turns the byte unknown
    if (uart_txd !== 1'b1) rx_byte = 8'hXX;
    rx_pulse <= 1'b1;
    @(posedge clk);
    rx_pulse <= 1'b0;
  end
endmodule : acc_host_model
`default_nettype wire

// >>> verification/adc_capture_controller_test.sv
// Self-checking bench for the capture controller
`timescale 1ns/1ns
`default_nettype none
module adc_capture_controller_test;
  import acc_pkg::*;
  logic        clk = 1'b0;
  logic        reset, alt_strobe, strobe, rxd, txd, oe, we_n, clk_out, led1, led2, led6, rx_pulse;
  logic [4:0]  sw;
  logic [17:0] conv_data, dat;
  logic [14:0] sram_addr;
  logic [23:0] dout, din;
  logic [7:0]  rx_byte;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          miscompares, checks, crise, lrise, c0, l0, n;
  logic [7:0]  exp_ser [$];
  logic [33:0] exp_rd [$];

  always #10 clk = ~clk;

  acc_capture #(.ALIVE_CYCLES(200)) uut (.clk(clk), .reset(reset), .sw(sw), .sample_valid_strobe(strobe),
    .alt_strobe(alt_strobe), .conv_data(conv_data), .uart_rxd(rxd), .uart_txd(txd), .sram_addr(sram_addr),
    .sram_dout(dout), .sram_oe(oe), .sram_din(din), .sram_we_n(we_n), .clk_out(clk_out), .led1(led1),
    .led2(led2), .led6(led6), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  acc_host_model host (.clk(clk), .uart_txd(txd), .uart_rxd(rxd), .strobe(strobe), .conv_data(conv_data),
    .sram_addr(sram_addr), .sram_dout(dout), .sram_oe(oe), .sram_we_n(we_n), .sram_din(din),
    .rx_byte(rx_byte), .rx_pulse(rx_pulse));

  // ==========================================
  // Comparison and closing
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // ==========================================
  // Result watchers
  always @(posedge clk) begin
    if (rx_pulse) check(34'(rx_byte), (exp_ser.size() != 0) ? 34'(exp_ser.pop_front()) : 34'hX);
    if (rvalid && rready) check({rresp, rdata}, (exp_rd.size() != 0) ? exp_rd.pop_front() : 34'hX);
  end
  always @(posedge clk_out) crise++;
  always @(posedge led6) lrise++;

  initial begin
    repeat (130000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  // ==========================================
  // Register bus master
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    check(34'(bresp), 34'(r));
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask : axi_rd

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'hFE82));
    {miscompares, checks, crise, lrise} = '0;
    {reset, alt_strobe, sw} = {1'b1, 1'b0, 5'h1F};
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    check(34'({led1, led2, txd}), 34'h5);
    axi_rd(A_CTRL, 34'h1);
    axi_rd(4'hC, {RESP_DECERR, 32'h0});
    axi_wr(4'hC, 32'h1, RESP_DECERR);
    // Check command with a live sample clock, flow state resumed
    host.run <= 1'b1;
    repeat (300) @(posedge clk);
    exp_ser.push_back(CMD_PING);
    host.send(CMD_PING);
    wait (exp_ser.size() == 0);
    // No answer without a sample clock
    host.run <= 1'b0;
    repeat (400) @(posedge clk);
    host.send(CMD_PING);
    axi_rd(A_STAT, 34'h1);
    // Start refused while disabled
    axi_wr(A_CTRL, 32'h0, RESP_OKAY);
    host.send(CMD_DIRECT);
    axi_rd(A_STAT, 34'h1);
    axi_wr(A_CTRL, 32'h1, RESP_OKAY);
    // Direct capture of a short random burst, switches 1 and 3 on: 16 bits
    sw <= 5'h05;
    n = 2 * $urandom_range(2, 4);
    dat = 18'($urandom) | 18'h0C000;
    host.send(CMD_DIRECT);
    c0 = crise;
    l0 = lrise;
    host.burst(n, dat);
    repeat (20) @(posedge clk);
    check(34'(crise - c0), 34'(n / 2));
    check(34'(lrise - l0), 34'(n));
    axi_rd(A_COUNT, 34'(n));
    axi_rd(A_STAT, 34'h1020);
    check(34'(uut.fifo_mem[0]), 34'(dat & 18'h0FFFF));
    sw <= 5'h1F;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check(34'({led1, led2}), 34'h2);
    // Histogram: pause early, bin 0 preloaded one short of 2048
    host.send(CMD_HIST);
    host.send(CH_PAUSE);
    do @(posedge clk); while (!(sram_addr == LAST_ADDR && !we_n));
    @(posedge clk);
    check(34'(host.mem[15'($urandom_range(1, 32767))]), 34'h0);
    host.mem[0] = 24'h0007FF;
    // 12-bit sample 800h with junk upper bits lands in bin 0
    host.burst(24, 18'h3F800);
    repeat (20) @(posedge clk);
    check(34'(host.mem[0]), 34'h000800);
    check(34'(led2), 34'h1);
    repeat (100) @(posedge clk);
    host.send(CH_RESUME);
    exp_ser.push_back(8'h00);
    exp_ser.push_back(8'h08);
    exp_ser.push_back(8'h00);
    wait (exp_ser.size() == 0);
    end_of_test();
  end
endmodule : adc_capture_controller_test
`default_nettype wire
